// ---- hdl/smd_core.sv ----
// Servo mode selection, servo-on gating and rotation direction
// Assumes synchronous inputs on clk_sys; mode, servo-on source and direction fields are latched at power-up
`timescale 1ns/1ps
module smd_core
  import smd_pkg::*;
#(
  parameter int PRESET_WIDTH = 16
)
(
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  // Parameter fields
  input  wire logic [3:0]                 control_mode_field,
  input  wire logic [3:0]                 servo_on_source_field,
  input  wire logic                       rotation_direction_field,
  input  wire logic [PRESET_WIDTH-1:0]    preset_speed [SMD_PRESET_COUNT],
  input  wire logic [1:0]                 preset_select,
  // Drive status and host inputs
  input  wire logic                       servo_on_in,
  input  wire logic                       main_power_ok,
  input  wire logic                       alarm_active,
  input  wire logic                       alarm_reset,
  input  wire logic                       motor_rotating,
  input  wire logic                       mode_switch,
  input  wire logic                       zero_clamp_in,
  input  wire logic                       pulse_inhibit_in,
  input  wire logic                       ref_forward,
  input  wire logic                       ref_reverse,
  input  wire logic                       ref_pulse,
  input  wire logic                       ref_pulse_dir,
  input  wire logic                       forward_limit_input,
  input  wire logic                       reverse_limit_input,
  input  wire smd_enc_t                   enc_in,
  // Outputs
  output smd_mode_t                       mode_out,
  output logic                            energized,
  output logic                            motor_invert,
  output logic                            overtravel_active,
  output logic [PRESET_WIDTH-1:0]         preset_speed_out,
  output logic signed [SMD_POS_WIDTH-1:0] position_cmd,
  output logic [SMD_RATE_WIDTH-1:0]       speed_cmd_rate,
  output smd_enc_t                        enc_out
);

  if (PRESET_WIDTH < 1 || PRESET_WIDTH > 32)
  begin
    $error("PRESET_WIDTH out of range");
  end

  // Decode one mode code plus switch level to a loop
  function automatic smd_mode_t decode_mode(input logic [3:0] code, input logic sw,
                                            input logic zc, input logic pi);
    smd_mode_t m;
    m = '{loop: SMD_LOOP_SPEED, zero_clamp: 1'b0, pulse_inhibit: 1'b0, fieldbus: 1'b0};
    unique case (code)
      SMD_MODE_SPEED:    m.loop = SMD_LOOP_SPEED;
      SMD_MODE_POSITION: m.loop = SMD_LOOP_POSITION;
      SMD_MODE_TORQUE:   m.loop = SMD_LOOP_TORQUE;
      SMD_MODE_PRESET:   m.loop = SMD_LOOP_PRESET;
      4'h4: m.loop = sw ? SMD_LOOP_SPEED    : SMD_LOOP_PRESET;
      4'h5: m.loop = sw ? SMD_LOOP_POSITION : SMD_LOOP_PRESET;
      4'h6: m.loop = sw ? SMD_LOOP_TORQUE   : SMD_LOOP_PRESET;
      4'h7: m.loop = sw ? SMD_LOOP_SPEED    : SMD_LOOP_POSITION;
      4'h8: m.loop = sw ? SMD_LOOP_TORQUE   : SMD_LOOP_POSITION;
      SMD_MODE_PAIR_LAST: m.loop = sw ? SMD_LOOP_SPEED : SMD_LOOP_TORQUE;
      SMD_MODE_SPD_CLAMP:
      begin
        m.loop       = SMD_LOOP_SPEED;
        m.zero_clamp = zc;
      end
      SMD_MODE_POS_INHIB:
      begin
        m.loop          = SMD_LOOP_POSITION;
        m.pulse_inhibit = pi;
      end
      SMD_MODE_FIELDBUS:
      begin
        m.loop     = SMD_LOOP_FIELDBUS;
        m.fieldbus = 1'b1;
      end
      default: m.loop = SMD_LOOP_SPEED;
    endcase
    return m;
  endfunction

  // Power-up latch of parameter fields
  logic       latched_reg, latched_next;
  logic [3:0] mode_code_reg, mode_code_next;
  logic       forced_reg, forced_next;
  logic       dir_reg, dir_next;

  always_comb
  begin
    latched_next   = 1'b1;
    mode_code_next = mode_code_reg;
    forced_next    = forced_reg;
    dir_next       = dir_reg;
    if (!latched_reg)
    begin
      mode_code_next = control_mode_field;
      forced_next    = (servo_on_source_field == SMD_SRC_FORCED);
      dir_next       = rotation_direction_field;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      latched_reg   <= 1'b0;
      mode_code_reg <= SMD_MODE_SPEED;
      forced_reg    <= 1'b0;
      dir_reg       <= SMD_DIR_CCW_FWD;
    end
    else
    begin
      latched_reg   <= latched_next;
      mode_code_reg <= mode_code_next;
      forced_reg    <= forced_next;
      dir_reg       <= dir_next;
    end
  end

  // Servo-on state machine
  smd_state_t state_reg, state_next;
  logic       req;
  logic       alarm_seen_reg, alarm_seen_next;

  always_comb
  begin
    req             = forced_reg | servo_on_in;
    state_next      = state_reg;
    alarm_seen_next = alarm_seen_reg | alarm_active;
    unique case (state_reg)
      SMD_ST_OFF:
        if (latched_reg && main_power_ok && !alarm_active && req && !motor_rotating)
        begin
          if (!alarm_seen_reg || !forced_reg || alarm_reset)
            state_next = SMD_ST_ARM;
        end
      SMD_ST_ARM:
        if (!req || alarm_active || !main_power_ok)
          state_next = SMD_ST_OFF;
        else
        begin
          state_next      = SMD_ST_ON;
          alarm_seen_next = 1'b0;
        end
      SMD_ST_ON:
        if (!req || alarm_active || !main_power_ok)
          state_next = SMD_ST_OFF;
      default: state_next = SMD_ST_OFF;
    endcase
    if (forced_reg && state_reg == SMD_ST_OFF && alarm_seen_reg && alarm_reset && !alarm_active)
      alarm_seen_next = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_reg      <= SMD_ST_OFF;
      alarm_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      alarm_seen_reg <= alarm_seen_next;
    end
  end

  // Mode, direction, limit and encoder outputs
  smd_mode_t                mode_reg, mode_next;
  logic                     energized_reg, energized_next;
  logic                     inv_reg, inv_next;
  logic                     ot_reg, ot_next;
  logic [PRESET_WIDTH-1:0]  preset_reg, preset_next;
  smd_enc_t                 enc_reg, enc_next;

  always_comb
  begin
    mode_next      = decode_mode(mode_code_reg, mode_switch, zero_clamp_in, pulse_inhibit_in);
    energized_next = (state_next == SMD_ST_ON);
    inv_next       = (dir_reg != SMD_DIR_CCW_FWD);
    ot_next        = (ref_forward & ~forward_limit_input) | (ref_reverse & ~reverse_limit_input);
    preset_next    = (preset_select < 2'(SMD_PRESET_COUNT)) ? preset_speed[preset_select] : '0;
    enc_next       = enc_in;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      mode_reg      <= '{loop: SMD_LOOP_SPEED, zero_clamp: 1'b0, pulse_inhibit: 1'b0, fieldbus: 1'b0};
      energized_reg <= 1'b0;
      inv_reg       <= 1'b0;
      ot_reg        <= 1'b0;
      preset_reg    <= '0;
      enc_reg       <= '{enc_a: 1'b0, enc_b: 1'b0};
    end
    else
    begin
      mode_reg      <= mode_next;
      energized_reg <= energized_next;
      inv_reg       <= inv_next;
      ot_reg        <= ot_next;
      preset_reg    <= preset_next;
      enc_reg       <= enc_next;
    end
  end

  // Pulse-train position and rate counters
  logic                            pulse_d_reg, pulse_d_next;
  logic signed [SMD_POS_WIDTH-1:0] pos_reg, pos_next;
  logic [SMD_RATE_WIDTH-1:0]       cnt_reg, cnt_next;
  logic [SMD_RATE_WIDTH-1:0]       rate_reg, rate_next;
  logic [31:0]                     win_reg, win_next;
  logic                            edge_ok;

  always_comb
  begin
    pulse_d_next = ref_pulse;
    edge_ok      = ref_pulse & ~pulse_d_reg & energized_reg & (mode_reg.loop == SMD_LOOP_POSITION)
                   & ~mode_reg.pulse_inhibit;
    pos_next     = pos_reg;
    cnt_next     = cnt_reg;
    rate_next    = rate_reg;
    win_next     = win_reg + 32'h1;
    if (edge_ok)
    begin
      pos_next = ref_pulse_dir ? pos_reg - 1 : pos_reg + 1;
      cnt_next = cnt_reg + 1'b1;
    end
    if (win_reg >= 32'(SMD_RATE_WIN_CYC - 1))
    begin
      win_next  = '0;
      rate_next = cnt_next;
      cnt_next  = '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      pulse_d_reg <= 1'b0;
      pos_reg     <= '0;
      cnt_reg     <= '0;
      rate_reg    <= '0;
      win_reg     <= '0;
    end
    else
    begin
      pulse_d_reg <= pulse_d_next;
      pos_reg     <= pos_next;
      cnt_reg     <= cnt_next;
      rate_reg    <= rate_next;
      win_reg     <= win_next;
    end
  end

  assign mode_out          = mode_reg;
  assign energized         = energized_reg;
  assign motor_invert      = inv_reg;
  assign overtravel_active = ot_reg;
  assign preset_speed_out  = preset_reg;
  assign position_cmd      = pos_reg;
  assign speed_cmd_rate    = rate_reg;
  assign enc_out           = enc_reg;

endmodule

// ---- hdl/smd_pkg.sv ----
// Constants and carrier types for the servo mode, enable and direction block
// Assumes one 40 MHz system clock and a synchronous active-high reset
// Overview of operation
// - Mode 0 analog speed, 1 pulse-train position, 2 analog torque.
// - Mode 3 regulates speed from one of three stored preset speeds.
// - Modes 4..9 select switchable pairs of basic modes in listed order.
// - Mode A speed with zero clamp option; B position with pulse inhibit.
// - Mode C hands drive operation to the fieldbus interface.
// - Position mode: pulse count is position, pulse rate is speed command.
// - Servo-on asserted energizes the drive; deasserted de-energizes it.
// - Servo-on request is refused while the motor is rotating.
// - Enable source 0 uses the pin, 7 forces on; latched at power-up.
// - Forced servo-on energizes as soon as main power is present.
// - Forced servo-on re-energizes automatically after an alarm reset.
// - Direction 0 counts CCW forward, 1 counts CW forward; reference polarity kept.
// - Direction setting never alters the encoder output phase relation.
// - Default direction counts CCW as forward, CW as reverse from load side.
package smd_pkg;

  localparam logic [3:0] SMD_MODE_SPEED      = 4'h0;
  localparam logic [3:0] SMD_MODE_POSITION   = 4'h1;
  localparam logic [3:0] SMD_MODE_TORQUE     = 4'h2;
  localparam logic [3:0] SMD_MODE_PRESET     = 4'h3;
  localparam logic [3:0] SMD_MODE_PAIR_FIRST = 4'h4;
  localparam logic [3:0] SMD_MODE_PAIR_LAST  = 4'h9;
  localparam logic [3:0] SMD_MODE_SPD_CLAMP  = 4'hA;
  localparam logic [3:0] SMD_MODE_POS_INHIB  = 4'hB;
  localparam logic [3:0] SMD_MODE_FIELDBUS   = 4'hC;

  localparam logic [3:0] SMD_SRC_PIN    = 4'h0;
  localparam logic [3:0] SMD_SRC_FORCED = 4'h7;

  localparam logic SMD_DIR_CCW_FWD = 1'b0;

  localparam int SMD_PRESET_COUNT = 3;
  localparam int SMD_POS_WIDTH    = 32;
  localparam int SMD_RATE_WIDTH   = 16;
  localparam int SMD_CLK_HZ       = 40_000_000;
  localparam int SMD_RATE_WIN_US  = 1000;
  localparam int SMD_RATE_WIN_CYC = SMD_CLK_HZ / 1_000_000 * SMD_RATE_WIN_US;

  // Active loop selected after mode decoding
  typedef enum logic [2:0] {
    SMD_LOOP_SPEED    = 3'h0,
    SMD_LOOP_POSITION = 3'h1,
    SMD_LOOP_TORQUE   = 3'h3,
    SMD_LOOP_PRESET   = 3'h2,
    SMD_LOOP_FIELDBUS = 3'h6
  } smd_loop_t;

  // Enable state machine, Gray along off, arming, on
  typedef enum logic [1:0] {
    SMD_ST_OFF = 2'b00,
    SMD_ST_ARM = 2'b01,
    SMD_ST_ON  = 2'b11
  } smd_state_t;

  typedef struct packed {
    smd_loop_t loop;
    logic      zero_clamp;
    logic      pulse_inhibit;
    logic      fieldbus;
  } smd_mode_t;

  typedef struct packed {
    logic enc_a;
    logic enc_b;
  } smd_enc_t;

endpackage

// ---- testbench/smd_core_asserts.sv ----
// Port checker for smd_core
// Assumes one clock, synchronous active-high reset, bound onto smd_core
`timescale 1ns/1ps
module smd_core_check
  import smd_pkg::*;
#(
  parameter int PRESET_WIDTH = 16
)
(
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       reset,
  // Inputs watched
  input wire logic [PRESET_WIDTH-1:0]    preset_speed [SMD_PRESET_COUNT],
  input wire logic [1:0]                 preset_select,
  input wire logic                       main_power_ok,
  input wire logic                       alarm_active,
  input wire logic                       motor_rotating,
  input wire logic                       ref_forward,
  input wire logic                       ref_reverse,
  input wire logic                       ref_pulse,
  input wire logic                       ref_pulse_dir,
  input wire logic                       forward_limit_input,
  input wire logic                       reverse_limit_input,
  input wire smd_enc_t                   enc_in,
  // Outputs watched
  input wire smd_mode_t                  mode_out,
  input wire logic                       energized,
  input wire logic                       overtravel_active,
  input wire logic [PRESET_WIDTH-1:0]    preset_speed_out,
  input wire logic signed [SMD_POS_WIDTH-1:0] position_cmd,
  input wire smd_enc_t                   enc_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  enc_pass_a: assert property (!$past(reset) && !$past(reset, 2) |-> enc_out == $past(enc_in))
    else $error("encoder outputs differ from inputs");
  alarm_drop_a: assert property (alarm_active |=> !energized)
    else $error("energized during alarm");
  power_drop_a: assert property (!main_power_ok |=> !energized)
    else $error("energized without main power");
  still_on_a: assert property ($rose(energized) |-> !$past(motor_rotating, 2))
    else $error("servo-on accepted while rotating");
  ot_fwd_a: assert property (ref_forward && !ref_reverse && !forward_limit_input && !$past(reset)
    |=> overtravel_active)
    else $error("forward overtravel missed");
  ot_clear_a: assert property (forward_limit_input && reverse_limit_input |=> !overtravel_active)
    else $error("overtravel without limit");
  preset_pick_a: assert property (mode_out.loop == SMD_LOOP_PRESET && $past(preset_select) == 2'h3
    && !$past(reset) |-> preset_speed_out == '0)
    else $error("preset index 3 not mapped to zero");
  preset_first_a: assert property ($past(preset_select) == 2'h0 && !$past(reset)
    |-> preset_speed_out == $past(preset_speed[0]))
    else $error("preset index 0 not passed");
  pos_hold_a: assert property (!energized |=> $stable(position_cmd))
    else $error("position moved while off");
  pos_count_a: assert property ($rose(ref_pulse) && !ref_pulse_dir && energized && !mode_out.pulse_inhibit
    && mode_out.loop == SMD_LOOP_POSITION |=> position_cmd == $past(position_cmd) + 1)
    else $error("pulse not counted");
  bus_loop_a: assert property (mode_out.fieldbus |-> mode_out.loop == SMD_LOOP_FIELDBUS)
    else $error("fieldbus flag with other loop");
endmodule

bind smd_core smd_core_check #(.PRESET_WIDTH(PRESET_WIDTH)) u_check (.*);

// ---- testbench/smd_host_model.sv ----
// Host model issuing a pulse-train position reference
// Assumes the bench raises send; pulses go out only while energized
`timescale 1ns/1ps
module smd_host_model
(
  // Clock and drive status
  input  wire logic clk_sys,
  input  wire logic energized,
  // Bench control
  input  wire logic send,
  input  wire logic down,
  // Reference outputs
  output logic      ref_pulse,
  output logic      ref_pulse_dir,
  output int        sent
);
  initial
  begin
    ref_pulse = 1'b0;
    ref_pulse_dir = 1'b0;
    sent = 0;
  end

  // Toggle on falling edges, count rising pulse edges
  always @(negedge clk_sys)
  begin
    ref_pulse_dir <= down;
    if (send && energized)
    begin
      ref_pulse <= !ref_pulse;
      if (!ref_pulse)
        sent <= down ? sent - 1 : sent + 1;
    end
  end
endmodule

// ---- testbench/servo_mode_enable_direction_test.sv ----
// Self-checking bench for smd_core
// Assumes the checker is bound in; inputs change on falling edges
`timescale 1ns/1ps
module servo_mode_enable_direction_test
  import smd_pkg::*;
;
  logic clk_sys, reset, rotation_direction_field, servo_on_in, main_power_ok, alarm_active, alarm_reset;
  logic motor_rotating, mode_switch, zero_clamp_in, pulse_inhibit_in, ref_forward, ref_reverse, send, down;
  logic forward_limit_input, reverse_limit_input, energized, motor_invert, overtravel_active, ref_pulse, ref_pulse_dir;
  logic [3:0]         control_mode_field, servo_on_source_field;
  logic [1:0]         preset_select;
  logic [15:0]        preset_speed [SMD_PRESET_COUNT];
  logic [15:0]        preset_speed_out, speed_cmd_rate;
  logic signed [31:0] position_cmd;
  smd_enc_t           enc_in, enc_out;
  smd_mode_t          mode_out;
  int                 n_mismatch, total_checks, sent, n_pulse, sent_before;

  smd_core dut (.clk_sys(clk_sys), .reset(reset), .control_mode_field(control_mode_field),
    .servo_on_source_field(servo_on_source_field), .rotation_direction_field(rotation_direction_field),
    .preset_speed(preset_speed), .preset_select(preset_select), .servo_on_in(servo_on_in),
    .main_power_ok(main_power_ok), .alarm_active(alarm_active), .alarm_reset(alarm_reset),
    .motor_rotating(motor_rotating), .mode_switch(mode_switch), .zero_clamp_in(zero_clamp_in),
    .pulse_inhibit_in(pulse_inhibit_in), .ref_forward(ref_forward), .ref_reverse(ref_reverse),
    .ref_pulse(ref_pulse), .ref_pulse_dir(ref_pulse_dir), .forward_limit_input(forward_limit_input),
    .reverse_limit_input(reverse_limit_input), .enc_in(enc_in), .mode_out(mode_out), .energized(energized),
    .motor_invert(motor_invert), .overtravel_active(overtravel_active), .preset_speed_out(preset_speed_out),
    .position_cmd(position_cmd), .speed_cmd_rate(speed_cmd_rate), .enc_out(enc_out));

  smd_host_model host (.clk_sys(clk_sys), .energized(energized), .send(send), .down(down),
    .ref_pulse(ref_pulse), .ref_pulse_dir(ref_pulse_dir), .sent(sent));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = !clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic restart(input logic [3:0] m, input logic [3:0] src, input logic d);
    control_mode_field = m;
    servo_on_source_field = src;
    rotation_direction_field = d;
    reset = 1'b1;
    tick(6);
    reset = 1'b0;
    tick(3);
  endtask

  // Expected loop per mode code and switch level
  function automatic logic [2:0] exp_loop(input int m, input int s);
    case (m)
      1, 11:   return SMD_LOOP_POSITION;
      2:       return SMD_LOOP_TORQUE;
      3:       return SMD_LOOP_PRESET;
      4:       return s ? SMD_LOOP_SPEED : SMD_LOOP_PRESET;
      5:       return s ? SMD_LOOP_POSITION : SMD_LOOP_PRESET;
      6:       return s ? SMD_LOOP_TORQUE : SMD_LOOP_PRESET;
      7:       return s ? SMD_LOOP_SPEED : SMD_LOOP_POSITION;
      8:       return s ? SMD_LOOP_TORQUE : SMD_LOOP_POSITION;
      9:       return s ? SMD_LOOP_SPEED : SMD_LOOP_TORQUE;
      12:      return SMD_LOOP_FIELDBUS;
      default: return SMD_LOOP_SPEED;
    endcase
  endfunction

  initial
  begin
    reset = 1'b1;
    {servo_on_in, alarm_active, alarm_reset, motor_rotating, send, down, mode_switch} = '0;
    {zero_clamp_in, pulse_inhibit_in, ref_forward, ref_reverse, preset_select, enc_in} = '0;
    {main_power_ok, forward_limit_input, reverse_limit_input} = 3'h7;
    {control_mode_field, servo_on_source_field, rotation_direction_field} = '0;
    void'($urandom(32'hDF6B8E2B));
    foreach (preset_speed[i])
      preset_speed[i] = 16'($urandom);
    for (int m = 0; m < 16; m++)
      for (int s = 0; s < 2; s++)
      begin
        {zero_clamp_in, pulse_inhibit_in} = 2'($urandom);
        preset_select = {s[0], s[0]};
        mode_switch = s[0];
        enc_in = smd_enc_t'(2'($urandom));
        restart(4'(m), 4'h0, s[0]);
        check("loop", 32'(mode_out.loop), 32'(exp_loop(m, s)));
        check("preset", 32'(preset_speed_out), s ? 32'h0 : 32'(preset_speed[0]));
        check("clamp", 32'(mode_out.zero_clamp), 32'(m == 10 && zero_clamp_in));
        check("inhibit", 32'(mode_out.pulse_inhibit), 32'(m == 11 && pulse_inhibit_in));
        check("fieldbus", 32'(mode_out.fieldbus), 32'(m == 12));
        check("invert", 32'(motor_invert), 32'(s));
        check("enc", 32'(enc_out), 32'(enc_in));
      end
    // Pin source: refused while rotating, then pulse counting
    mode_switch = 1'b0;
    restart(4'h1, 4'h0, 1'b0);
    servo_on_in = 1'b1;
    motor_rotating = 1'b1;
    tick(5);
    check("refuse", 32'(energized), 32'h0);
    motor_rotating = 1'b0;
    tick(2);
    check("on", 32'(energized), 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      down = 1'($urandom);
      sent_before = sent;
      send = 1'b1;
      tick(2 * int'($urandom_range(20, 1)));
      send = 1'b0;
      tick(2);
      check("position", 32'(position_cmd), 32'(sent));
      n_pulse += (sent > sent_before) ? sent - sent_before : sent_before - sent;
    end
    for (int i = 0; i < 8; i++)
    begin
      {reverse_limit_input, forward_limit_input, ref_forward} = 3'(i);
      ref_reverse = !ref_forward;
      tick(2);
      check("ot", 32'(overtravel_active), 32'(ref_forward ? !forward_limit_input : !reverse_limit_input));
    end
    servo_on_in = 1'b0;
    tick(2);
    check("off", 32'(energized), 32'h0);
    // First rate window closes after all bursts
    tick(SMD_RATE_WIN_CYC);
    check("rate", 32'(speed_cmd_rate), 32'(n_pulse));
    // Forced source: power-up, alarm, alarm reset
    main_power_ok = 1'b0;
    restart(4'h0, 4'h7, 1'b0);
    check("nopower", 32'(energized), 32'h0);
    main_power_ok = 1'b1;
    tick(3);
    check("forced", 32'(energized), 32'h1);
    // Field changes after power-up are ignored
    servo_on_source_field = 4'h0;
    control_mode_field = 4'h2;
    tick(2);
    check("latched", 32'(energized), 32'h1);
    check("latchmode", 32'(mode_out.loop), 32'(SMD_LOOP_SPEED));
    alarm_active = 1'b1;
    tick(2);
    alarm_active = 1'b0;
    tick(3);
    check("alarm", 32'(energized), 32'h0);
    alarm_reset = 1'b1;
    tick(1);
    alarm_reset = 1'b0;
    tick(4);
    check("rearm", 32'(energized), 32'h1);
    print_verdict();
  end

  // Watchdog
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule
